// ### common/mcl_pkg.sv
// constants and types for the misc control register block
package mcl_pkg;
	localparam int MCL_ADDR_W = 8;
	localparam int MCL_DATA_W = 8;
	// register index as printed; byte address is four times it
	localparam logic [7:0] MCL_MISC_IDX = 8'h09;
	localparam logic [7:0] MCL_MISC_ADDR = 8'h24;
	// own status register: pin levels and mode
	localparam logic [7:0] MCL_STAT_ADDR = 8'h28;
	localparam int MCL_BIT_REORDER = 7;
	localparam int MCL_BIT_POLARITY = 6;
	localparam int MCL_BIT_RSVD = 5;
	localparam int MCL_BIT_ACT_DET = 4;
	localparam logic [7:0] MCL_MISC_RESET = 8'h02;
	localparam logic [7:0] MCL_WRITE_MASK = 8'hdf;
	localparam logic [7:0] MCL_STRAP_MASK = 8'hd0;
	localparam logic [1:0] MCL_SYNC_RESET = 2'h0;
	typedef enum logic [2:0]
	{
		MCL_IDLE = 3'b001,
		MCL_ACK = 3'b010,
		MCL_WAIT = 3'b100
	} mcl_bus_state_type;
endpackage

// ### common/mcl_reg_if.sv
// internal register access channel between bus slave and register file
interface mcl_reg_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave_side (output wr_en, output addr, output wdata, input rdata);
	modport regs_side (input wr_en, input addr, input wdata, output rdata);
endinterface

// ### core/mcl_misc_ctrl.sv
// misc control register with strap loading and lane control outputs
// What this block does
// - the lane reorder bit resets to zero for straight lanes and one reorders the input lanes.
// - a set reorder bit applies in both redriver and retimer operation.
// - while port select is low, the reorder bit follows the synchronised lane reorder strap pin.
// - while port select is low, writes to the reorder field are dropped and the strap value stays.
// - bit 5 is read only, bits 7, 6 and 4 are writable and hardware loaded, bits 3 to 0 plain read/write.
// - bit 6 inverts input data and clock lane polarity in retimer operation only, reset zero.
// - bit 4 enables the clock activity detector which sends the receiver to standby without valid data.
// - register writes are accepted only while port select is high, otherwise straps configure; reads work in both.
//
// The Wishbone register port was chosen for this implementation.
module mcl_misc_ctrl
	import mcl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	input wire logic port_select_i,
	input wire logic reorder_strap_i,
	input wire logic polarity_strap_i,
	input wire logic activity_strap_i,
	input wire logic retimer_mode_i,
	input wire logic data_valid_i,
	output logic lane_reorder_o,
	output logic lane_polarity_invert_o,
	output logic clock_activity_detect_enable_o,
	output logic rx_standby_o,
	output logic [3:0] misc_low_o
);
	mcl_reg_if regs();
	// pin levels in status bit order: select, reorder, polarity, detect
	logic [3:0] pin_raw;
	logic [3:0] pin_sync;
	logic sel_q;
	logic reorder_q;
	logic polarity_q;
	logic activity_q;
	logic strap_mode;
	logic misc_hit;
	logic stat_hit;
	logic bus_write;
	logic [7:0] misc_value;
	logic reorder_reg;
	logic reorder_next;
	logic polarity_reg;
	logic polarity_next;
	logic act_det_reg;
	logic act_det_next;
	logic [3:0] plain_reg;
	logic [3:0] plain_next;
	logic lane_reorder_reg;
	logic lane_reorder_next;
	logic polarity_out_reg;
	logic polarity_out_next;
	logic act_en_reg;
	logic act_en_next;
	logic standby_reg;
	logic standby_next;
	logic [3:0] low_reg;
	logic [3:0] low_next;

	////////////////////////////////////////////////////////////////
	mcl_wb_slave u_slave
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.sel_i(sel_i),
		.adr_i(adr_i),
		.dat_i(dat_i),
		.ack_o(ack_o),
		.dat_o(dat_o),
		.regs(regs.slave_side)
	);

	////////////////////////////////////////////////////////////////
	// the select and three strap pins cross two flip-flops before any logic reads them
	assign pin_raw = {port_select_i, reorder_strap_i, polarity_strap_i, activity_strap_i};

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_pin_sync
			mcl_sync u_sync
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.d_i(pin_raw[i]),
				.q_o(pin_sync[i])
			);
		end
	endgenerate

	assign sel_q = pin_sync[3];
	assign reorder_q = pin_sync[2];
	assign polarity_q = pin_sync[1];
	assign activity_q = pin_sync[0];

	////////////////////////////////////////////////////////////////
	// address decode and the write qualifier
	always_comb
	begin
		misc_hit = (regs.addr == MCL_MISC_ADDR);
		stat_hit = (regs.addr == MCL_STAT_ADDR);
		// register writes only while port select is high
		strap_mode = !sel_q;
		bus_write = regs.wr_en && misc_hit && !strap_mode;
	end

	////////////////////////////////////////////////////////////////
	// bit 5 has no storage and always reads zero
	always_comb
	begin
		misc_value = 8'h00;
		misc_value[MCL_BIT_REORDER] = reorder_reg;
		misc_value[MCL_BIT_POLARITY] = polarity_reg;
		misc_value[MCL_BIT_RSVD] = 1'b0;
		misc_value[MCL_BIT_ACT_DET] = act_det_reg;
		misc_value[3:0] = plain_reg;
	end

	// read mux, unmapped addresses read zero
	always_comb
	begin
		if (misc_hit)
		begin
			regs.rdata = misc_value;
		end
		else if (stat_hit)
		begin
			regs.rdata = {4'h0, pin_sync};
		end
		else
		begin
			regs.rdata = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// lane reorder bit, clear means straight lanes
	always_comb
	begin
		reorder_next = reorder_reg;
		if (bus_write)
		begin
			reorder_next = regs.wdata[MCL_BIT_REORDER];
		end
		// strap level reloaded each cycle; so a write is lost
		if (strap_mode)
		begin
			reorder_next = reorder_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			reorder_reg <= MCL_MISC_RESET[MCL_BIT_REORDER];
		end
		else
		begin
			reorder_reg <= reorder_next;
		end
	end

	// polarity bit, strap loaded like the reorder bit
	always_comb
	begin
		polarity_next = polarity_reg;
		if (bus_write)
		begin
			polarity_next = regs.wdata[MCL_BIT_POLARITY];
		end
		// strap wins over a write landing in the same cycle
		if (strap_mode)
		begin
			polarity_next = polarity_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			polarity_reg <= MCL_MISC_RESET[MCL_BIT_POLARITY];
		end
		else
		begin
			polarity_reg <= polarity_next;
		end
	end

	always_comb
	begin
		act_det_next = act_det_reg;
		if (bus_write)
		begin
			act_det_next = regs.wdata[MCL_BIT_ACT_DET];
		end
		// strap wins over a write landing in the same cycle
		if (strap_mode)
		begin
			act_det_next = activity_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			act_det_reg <= MCL_MISC_RESET[MCL_BIT_ACT_DET];
		end
		else
		begin
			act_det_reg <= act_det_next;
		end
	end

	// bits 3 to 0 are plain read/write
	always_comb
	begin
		plain_next = plain_reg;
		if (bus_write)
		begin
			plain_next = regs.wdata[3:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			plain_reg <= MCL_MISC_RESET[3:0];
		end
		else
		begin
			plain_reg <= plain_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs come from flops, one cycle behind the register
	always_comb
	begin
		// reorder applies in redriver and retimer operation
		lane_reorder_next = reorder_reg;
		polarity_out_next = polarity_reg && retimer_mode_i;
		// standby while the detector sees no valid data
		act_en_next = act_det_reg;
		standby_next = act_det_reg && !data_valid_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lane_reorder_reg <= MCL_MISC_RESET[MCL_BIT_REORDER];
			polarity_out_reg <= MCL_MISC_RESET[MCL_BIT_POLARITY];
			act_en_reg <= MCL_MISC_RESET[MCL_BIT_ACT_DET];
			standby_reg <= MCL_MISC_RESET[MCL_BIT_ACT_DET];
		end
		else
		begin
			lane_reorder_reg <= lane_reorder_next;
			polarity_out_reg <= polarity_out_next;
			act_en_reg <= act_en_next;
			standby_reg <= standby_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// plain bits mirrored out to the rest of the core
	always_comb
	begin
		low_next = plain_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			low_reg <= MCL_MISC_RESET[3:0];
		end
		else
		begin
			low_reg <= low_next;
		end
	end

	assign lane_reorder_o = lane_reorder_reg;
	assign lane_polarity_invert_o = polarity_out_reg;
	assign clock_activity_detect_enable_o = act_en_reg;
	assign rx_standby_o = standby_reg;
	assign misc_low_o = low_reg;
endmodule

// ### core/mcl_sync.sv
// two flip-flop synchroniser for one pin level
module mcl_sync
	import mcl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic [1:0] sync_reg;
	logic [1:0] sync_next;

	always_comb
	begin
		sync_next = {sync_reg[0], d_i};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sync_reg <= MCL_SYNC_RESET;
		else
			sync_reg <= sync_next;
	end

	assign q_o = sync_reg[1];
endmodule

// ### core/mcl_wb_slave.sv
// classic wishbone slave, one wait state, drives the register channel
module mcl_wb_slave
	import mcl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	mcl_reg_if.slave_side regs
);
	mcl_bus_state_type state_reg;
	mcl_bus_state_type state_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;

	assign regs.addr = adr_i;
	assign regs.wdata = dat_i[7:0];

	always_comb
	begin
		state_next = state_reg;
		ack_next = 1'b0;
		dat_next = dat_reg;
		regs.wr_en = 1'b0;
		case (state_reg)
			MCL_IDLE:
			begin
				if (cyc_i && stb_i)
				begin
					// write commits at the edge where ack rises
					regs.wr_en = we_i && sel_i[0];
					dat_next = {24'h000000, regs.rdata};
					ack_next = 1'b1;
					state_next = MCL_ACK;
				end
			end
			MCL_ACK:
				state_next = MCL_WAIT;
			MCL_WAIT:
			begin
				// master must drop stb before the next request
				if (!(cyc_i && stb_i))
					state_next = MCL_IDLE;
			end
			default:
				state_next = MCL_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= MCL_IDLE;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end
		else
		begin
			state_reg <= state_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
endmodule

// ### tb/mcl_host.sv
// wishbone master standing in for the configuring bus host
module mcl_host
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [3:0] sel_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
	// one access; hung tells the caller no answer came
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q, output bit hung);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'h3, w, 4'h1, a, 24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 20);
		q = dat_i[7:0];
		hung = (ack_i !== 1'b1);
		{cyc_o, stb_o} <= 2'h0;
	endtask
endmodule

// ### tb/mcl_misc_ctrl_checker.sv
// port assertions for the misc control register
module mcl_misc_ctrl_checker
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	input wire logic port_select_i,
	input wire logic reorder_strap_i,
	input wire logic retimer_mode_i,
	input wire logic data_valid_i,
	input wire logic lane_reorder_o,
	input wire logic lane_polarity_invert_o,
	input wire logic clock_activity_detect_enable_o,
	input wire logic rx_standby_o,
	input wire logic [3:0] misc_low_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_answer_a: assert property ($rose(stb_i) && cyc_i |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle after request");
	read_shape_a: assert property (ack_o && !we_i && adr_i == 8'h24 |-> dat_o[5] == 0 && dat_o[31:8] == 0)
		else $error("reserved read bits not zero");
	read_match_a: assert property (ack_o && !we_i && adr_i == 8'h24 |-> dat_o[7] == lane_reorder_o)
		else $error("reorder output differs from register");
	wr_effect_a: assert property (port_select_i[*4] ##0 (ack_o && we_i && adr_i == 8'h24) |=>
		{lane_reorder_o, misc_low_o} == {$past(dat_i[7]), $past(dat_i[3:0])})
		else $error("register write not applied");
	strap_lock_a: assert property ((!port_select_i)[*4] |=> $stable(misc_low_o))
		else $error("low bits changed in strap mode");
	strap_load_a: assert property ((!port_select_i && $stable(reorder_strap_i))[*6] |=>
		lane_reorder_o == $past(reorder_strap_i))
		else $error("reorder bit not loaded from strap");
	polarity_a: assert property (lane_polarity_invert_o |-> $past(retimer_mode_i))
		else $error("polarity invert outside retimer mode");
	standby_a: assert property (rx_standby_o |-> clock_activity_detect_enable_o && !$past(data_valid_i))
		else $error("standby without enable or with valid data");
endmodule

// ### tb/mcl_misc_ctrl_test.sv
// self-checking bench for the misc control register
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module mcl_misc_ctrl_test;
	import mcl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, port_select_i = 1, retimer_mode_i = 0, data_valid_i = 0;
	logic reorder_strap_i = 0, polarity_strap_i = 0, activity_strap_i = 0;
	logic cyc_i, stb_i, we_i, ack_o, lane_reorder_o, lane_polarity_invert_o, clock_activity_detect_enable_o;
	logic rx_standby_o;
	logic [3:0] sel_i, misc_low_o;
	logic [7:0] adr_i, q, v;
	logic [31:0] dat_i, dat_o;
	int fails = 0, n_tests = 0, seed = 52;
	bit hung;
	mcl_misc_ctrl i_mcl_misc_ctrl (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .ack_o, .dat_o,
		.port_select_i, .reorder_strap_i, .polarity_strap_i, .activity_strap_i, .retimer_mode_i, .data_valid_i,
		.lane_reorder_o, .lane_polarity_invert_o, .clock_activity_detect_enable_o, .rx_standby_o, .misc_low_o);
	mcl_host i_mcl_host (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
		.sel_o(sel_i), .adr_o(adr_i), .dat_o(dat_i));
	initial forever #25 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_strap(logic [7:0] d);
		return {reorder_strap_i, polarity_strap_i, 1'b0, activity_strap_i, d[3:0]};
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d);
		i_mcl_host.xfer(w, a, d, q, hung);
		if (hung)
		begin
			fails++;
			wrap_up();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		acc(0, MCL_MISC_ADDR, 0);
		`CHK(q, 8'h02)
		`CHK(lane_reorder_o, 1'b0)
		acc(0, 8'h40, 0);
		`CHK(q, 8'h00)
		acc(0, MCL_STAT_ADDR, 0);
		`CHK(q, {4'h0, 1'b1, reorder_strap_i, polarity_strap_i, activity_strap_i})
		$display("test reset done");
		// corner values first, then random ones
		for (int k = 0; k < 8; k++)
		begin
			v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
			retimer_mode_i <= 1'($random(seed));
			data_valid_i <= 1'($random(seed));
			acc(1, MCL_MISC_ADDR, v);
			acc(0, MCL_MISC_ADDR, 0);
			`CHK(q, {v[7:6], 1'b0, v[4:0]})
			`CHK(lane_reorder_o, v[7])
			`CHK(lane_polarity_invert_o, v[6] & retimer_mode_i)
			`CHK(clock_activity_detect_enable_o, v[4])
			`CHK(rx_standby_o, v[4] & ~data_valid_i)
			`CHK(misc_low_o, v[3:0])
		end
		acc(1, 8'h40, 8'hff);
		acc(0, MCL_MISC_ADDR, 0);
		`CHK(q, {v[7:6], 1'b0, v[4:0]})
		$display("test register mode done");
		port_select_i <= 0;
		repeat (4)
		begin
			{reorder_strap_i, polarity_strap_i, activity_strap_i} <= 3'($random(seed));
			repeat (5) @(posedge clk_i);
			acc(1, MCL_MISC_ADDR, ~v);
			acc(0, MCL_MISC_ADDR, 0);
			`CHK(q, exp_strap(v))
			`CHK(lane_reorder_o, reorder_strap_i)
			`CHK(lane_polarity_invert_o, polarity_strap_i & retimer_mode_i)
			`CHK(clock_activity_detect_enable_o, activity_strap_i)
			`CHK(rx_standby_o, activity_strap_i & ~data_valid_i)
			`CHK(misc_low_o, v[3:0])
			acc(0, MCL_STAT_ADDR, 0);
			`CHK(q, {4'h0, 1'b0, reorder_strap_i, polarity_strap_i, activity_strap_i})
		end
		// back to register mode: writes land again
		port_select_i <= 1;
		repeat (3) @(posedge clk_i);
		acc(1, MCL_MISC_ADDR, v);
		acc(0, MCL_MISC_ADDR, 0);
		`CHK(q, {v[7:6], 1'b0, v[4:0]})
		$display("test strap mode done");
		wrap_up();
	end
endmodule
bind mcl_misc_ctrl mcl_misc_ctrl_checker i_mcl_misc_ctrl_checker (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
	.dat_i, .ack_o, .dat_o, .port_select_i, .reorder_strap_i, .retimer_mode_i, .data_valid_i, .lane_reorder_o,
	.lane_polarity_invert_o, .clock_activity_detect_enable_o, .rx_standby_o, .misc_low_o);
